// ===== core/vdst_pkg.sv
// Constants, types and helpers shared by the voltage detector self test.
// Overview of operation
// (R01) Writing 01 to mode with no detector selected starts full sweep.
// (R02) Full sweep end clears the mode field.
// (R03) Detector select of 1 to 8 tests that detector only.
// (R04) Single test end leaves mode field unchanged.
// (R05) Clearing outcome flag with mode non-zero reruns.
// (R06) Software zeroes mode before clearing outcome flag.
// (R07) Any test end sets sticky outcome flag.
`default_nettype none
package vdst_pkg;
    // Number of detector events: undervoltage and overvoltage together.
    localparam int VDST_DET_COUNT = 8;
    // Field widths of the software controls, the detector index and the counter.
    localparam int VDST_MODE_W = 2;
    localparam int VDST_SEL_W = 4;
    localparam int VDST_IDX_W = 3;
    localparam int VDST_CNT_W = 8;
    // Field, index and stimulus encodings and reset values.
    localparam logic [1:0] VDST_MODE_OFF = 2'h0;
    localparam logic [1:0] VDST_MODE_FULL = 2'h1;
    localparam logic [3:0] VDST_SEL_NONE = 4'h0;
    localparam logic [3:0] VDST_SEL_MAX = 4'h8;
    localparam logic [2:0] VDST_IDX_FIRST = 3'h0;
    localparam logic [2:0] VDST_IDX_LAST = 3'h7;
    localparam logic [7:0] VDST_STIM_NONE = 8'h00;
    // Clock period and detector timing, in nanoseconds.
    localparam int VDST_CLK_NS = 50;
    localparam int VDST_SETTLE_NS = 5000;
    localparam int VDST_GAP_NS = 2000;
    // Least times round up to whole cycles.
    localparam logic [7:0] VDST_SETTLE_CYC =
        8'((VDST_SETTLE_NS + VDST_CLK_NS - 1) / VDST_CLK_NS);
    localparam logic [7:0] VDST_GAP_CYC =
        8'((VDST_GAP_NS + VDST_CLK_NS - 1) / VDST_CLK_NS);
    localparam logic [7:0] VDST_CNT_ZERO = 8'h00;
    localparam logic [7:0] VDST_CNT_ONE = 8'h01;

    // Sequencer states.
    typedef enum logic [1:0] {
        VDST_IDLE,
        VDST_STIM,
        VDST_CHECK,
        VDST_GAP
    } vdst_state_e;

    // One software access cycle to the detector test user register.
    typedef struct packed {
        logic mode_wr;
        logic [1:0] mode_data;
        logic sel_wr;
        logic [3:0] sel_data;
        logic flag_clr;
    } vdst_sw_wr_s;

    // A select value names a detector when it is 1 to 8.
    function automatic logic vdst_sel_valid(input logic [3:0] sel);
        return (sel != VDST_SEL_NONE) && (sel <= VDST_SEL_MAX);
    endfunction : vdst_sel_valid

    // One-hot stimulus for a detector index.
    function automatic logic [7:0] vdst_onehot(input logic [2:0] idx);
        return 8'(8'h01 << idx);
    endfunction : vdst_onehot
endpackage : vdst_pkg
`default_nettype wire

// ===== core/vdst_sync.sv
// Two-stage synchroniser for the analog detector response lines.
`default_nettype none
module vdst_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] async_in,
    output logic [7:0] sync_out
);
    import vdst_pkg::*;

    // First stage; read only by the second stage.
    logic [7:0] meta_reg;

    // Comparator outputs are asynchronous, so they pass two flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= VDST_STIM_NONE;
            sync_out <= VDST_STIM_NONE;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : vdst_sync
`default_nettype wire

// ===== core/vdst_top.sv
// Self-test sequencer for the undervoltage and overvoltage detectors.
`default_nettype none
module vdst_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire vdst_pkg::vdst_sw_wr_s sw_wr,
    input wire logic [7:0] detector_response,
    output logic [1:0] test_mode_select,
    output logic [3:0] single_detector_select,
    output logic test_outcome_flag,
    output logic test_pass,
    output logic test_busy,
    output logic [7:0] detector_stimulus
);
    import vdst_pkg::*;

    // Synchronised detector responses.
    logic [7:0] resp_sync;
    // Sequencer state and its next value.
    vdst_state_e state_reg;
    vdst_state_e state_next;
    // Detector under test and the settle or gap counter.
    logic [2:0] idx_reg;
    logic [7:0] cnt_reg;
    // High while the running test is a single-detector test.
    logic single_reg;
    // Values the register fields take after this cycle's write.
    logic [1:0] mode_eff;
    logic [3:0] sel_eff;
    // Sequencing events.
    logic start_trig;
    logic launch;
    logic launch_single;
    logic last_det;
    logic to_next;
    logic finish;
    logic cnt_done;

    vdst_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(detector_response),
        .sync_out(resp_sync)
    );

    // Start decoding. A clear of the outcome flag while the mode field is
    // still non-zero is taken as a fresh start; that is why software must
    // zero the mode field first after a single test.
    always_comb begin
        mode_eff = sw_wr.mode_wr ? sw_wr.mode_data : test_mode_select;
        sel_eff = sw_wr.sel_wr ? sw_wr.sel_data : single_detector_select;
        start_trig = (sw_wr.mode_wr && (sw_wr.mode_data != VDST_MODE_OFF))
            || (sw_wr.sel_wr && (sw_wr.sel_data != VDST_SEL_NONE)
                && (mode_eff != VDST_MODE_OFF)) // R03
            || (sw_wr.flag_clr && (test_mode_select != VDST_MODE_OFF)); // R05
        launch_single = vdst_sel_valid(sel_eff); // R03
        // A start is honoured only when the sequencer is idle.
        launch = (state_reg == VDST_IDLE) && start_trig
            && (launch_single || (mode_eff == VDST_MODE_FULL)); // R01
        cnt_done = (cnt_reg == VDST_CNT_ZERO);
        last_det = single_reg || (idx_reg == VDST_IDX_LAST);
        to_next = (state_reg == VDST_GAP) && cnt_done && !last_det;
        finish = (state_reg == VDST_GAP) && cnt_done && last_det;
    end

    // Next-state decode of the sequencer.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            VDST_IDLE: begin
                // Wait for software to start a test.
                if (launch) begin
                    state_next = VDST_STIM;
                end
            end
            VDST_STIM: begin
                // Hold the stimulus until the detector has settled.
                if (cnt_done) begin
                    state_next = VDST_CHECK;
                end
            end
            VDST_CHECK: begin
                // One cycle to sample the response.
                state_next = VDST_GAP;
            end
            VDST_GAP: begin
                // Let the detector recover before the next one.
                if (finish) begin
                    state_next = VDST_IDLE;
                end else if (to_next) begin
                    state_next = VDST_STIM;
                end
            end
            default: begin
                state_next = VDST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= VDST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Detector index and test kind, set at launch; the index steps on to the next detector at each to_next of a full sweep.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_reg <= VDST_IDX_FIRST;
            single_reg <= 1'b0;
        end else if (launch) begin
            single_reg <= launch_single;
            idx_reg <= launch_single ? 3'(sel_eff - 4'h1) : VDST_IDX_FIRST;
        end else if (to_next) begin
            idx_reg <= idx_reg + 3'h1; // R01
        end
    end

    // Settle and gap counter; it is loaded with one less than the time
    // because the loading cycle itself counts.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= VDST_CNT_ZERO;
        end else if (launch || to_next) begin
            cnt_reg <= VDST_SETTLE_CYC - VDST_CNT_ONE;
        end else if (state_reg == VDST_CHECK) begin
            cnt_reg <= VDST_GAP_CYC - VDST_CNT_ONE;
        end else if (!cnt_done) begin
            cnt_reg <= cnt_reg - VDST_CNT_ONE;
        end
    end

    // Stimulus drive: at most one detector is forced at a time.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            detector_stimulus <= VDST_STIM_NONE;
        end else if (launch) begin
            detector_stimulus <= vdst_onehot(launch_single ?
                3'(sel_eff - 4'h1) : VDST_IDX_FIRST); // R03
        end else if (to_next) begin
            detector_stimulus <= vdst_onehot(idx_reg + 3'h1); // R01
        end else if (state_reg == VDST_CHECK) begin
            detector_stimulus <= VDST_STIM_NONE;
        end
    end

    // Pass status: set at launch, dropped by any detector that stays quiet.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_pass <= 1'b0;
        end else if (launch) begin
            test_pass <= 1'b1;
        end else if ((state_reg == VDST_CHECK) && !resp_sync[idx_reg]) begin
            test_pass <= 1'b0;
        end
    end

    // Busy flag follows the sequencer.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_busy <= 1'b0;
        end else begin
            test_busy <= (state_next != VDST_IDLE);
        end
    end

    // Mode field. The hardware clear after a full sweep loses to a
    // software write in the same cycle, so software intent is never lost.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_mode_select <= VDST_MODE_OFF;
        end else if (sw_wr.mode_wr) begin
            test_mode_select <= sw_wr.mode_data;
        end else if (finish && !single_reg) begin // R04
            test_mode_select <= VDST_MODE_OFF; // R02
        end
        // A single test leaves the field alone at the end.
    end

    // Detector select field, written by software only.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            single_detector_select <= VDST_SEL_NONE;
        end else if (sw_wr.sel_wr) begin
            single_detector_select <= sw_wr.sel_data;
        end
    end

    // Outcome flag: completion wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            test_outcome_flag <= 1'b0;
        end else if (finish) begin
            test_outcome_flag <= 1'b1; // R07
        end else if (sw_wr.flag_clr) begin
            test_outcome_flag <= 1'b0;
        end
    end

    property p_full_start;
        @(posedge clk) disable iff (!rst_n)
        launch && !launch_single
            |=> test_busy
                && (detector_stimulus == vdst_onehot(VDST_IDX_FIRST))
                ##1 (detector_stimulus == vdst_onehot(VDST_IDX_FIRST)) [*8];
    endproperty
    a_full_start: assert property (p_full_start) // R01
        else $error("Full sweep did not start on detector zero.");

    property p_full_clear;
        @(posedge clk) disable iff (!rst_n)
        finish && !single_reg && !sw_wr.mode_wr
            |=> (test_mode_select == VDST_MODE_OFF) && !test_busy;
    endproperty
    a_full_clear: assert property (p_full_clear) // R02
        else $error("Mode field not cleared after full sweep.");

    property p_single_one;
        @(posedge clk) disable iff (!rst_n)
        launch && launch_single
            |=> (detector_stimulus == vdst_onehot(3'($past(sel_eff) - 4'h1)))
                && ($countones(detector_stimulus) == 1);
    endproperty
    a_single_one: assert property (p_single_one) // R03
        else $error("Single test drove the wrong detector.");

    property p_single_keep;
        @(posedge clk) disable iff (!rst_n)
        finish && single_reg && !sw_wr.mode_wr
            |=> test_mode_select == $past(test_mode_select);
    endproperty
    a_single_keep: assert property (p_single_keep) // R04
        else $error("Mode field changed after single test.");

    // Only a rerun of a single test is bounded here; a full sweep rerun
    // takes longer than the window and is covered by the flag checks.
    property p_rerun;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == VDST_IDLE) && sw_wr.flag_clr && !sw_wr.mode_wr
            && !sw_wr.sel_wr && (test_mode_select != VDST_MODE_OFF)
            && vdst_sel_valid(single_detector_select)
            |=> test_busy ##[1:300] test_outcome_flag;
    endproperty
    a_rerun: assert property (p_rerun) // R05
        else $error("Clearing the flag with mode set did not rerun.");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_n)
        finish |=> test_outcome_flag && !test_busy;
    endproperty
    a_flag_set: assert property (p_flag_set) // R07
        else $error("Outcome flag not set at test end.");

    property p_flag_hold;
        @(posedge clk) disable iff (!rst_n)
        test_outcome_flag && !sw_wr.flag_clr |=> test_outcome_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) // R07
        else $error("Outcome flag fell without a clear.");
endmodule : vdst_top
`default_nettype wire

// ===== testbench/tb_vdst_top.sv
// Self-checking bench for the voltage detector self-test sequencer.
`default_nettype none
module tb_vdst_top;
    timeunit 1ns;
    timeprecision 1ns;
    import vdst_pkg::*;

    logic clk; // System clock, 50 ns period.
    logic rst_n; // Asynchronous reset, active low.
    vdst_sw_wr_s sw_wr; // One software access cycle.
    logic [7:0] detector_response; // Detector outputs seen by the block.
    logic [1:0] test_mode_select;
    logic [3:0] single_detector_select;
    logic test_outcome_flag;
    logic test_pass;
    logic test_busy;
    logic [7:0] detector_stimulus;
    logic echo; // When high the detectors answer their stimulus.
    int n_errors; // Mismatches seen.
    int checks; // Comparisons made.

    vdst_top DUT (
        .clk(clk),
        .rst_n(rst_n),
        .sw_wr(sw_wr),
        .detector_response(detector_response),
        .test_mode_select(test_mode_select),
        .single_detector_select(single_detector_select),
        .test_outcome_flag(test_outcome_flag),
        .test_pass(test_pass),
        .test_busy(test_busy),
        .detector_stimulus(detector_stimulus)
    );

    // Free-running clock at 20 MHz.
    always #25 clk = ~clk;

    // Healthy detectors trip on their own stimulus; a dead one never does.
    always @(negedge clk) begin
        detector_response <= echo ? detector_stimulus : 8'h00;
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // One-cycle software access; the leading edge wait keeps two calls
    // from assigning the strobes twice in one time step.
    task automatic sw(input logic mw, input logic [1:0] md, input logic sw_e,
                      input logic [3:0] sd, input logic fc);
        @(negedge clk);
        sw_wr <= '{mode_wr: mw, mode_data: md, sel_wr: sw_e,
                   sel_data: sd, flag_clr: fc};
        @(negedge clk);
        sw_wr <= '0;
    endtask : sw

    // Waits a bounded time for a test to end; stimulus outside mask is
    // remembered as a fault.
    task automatic wait_done(input int bound, input logic [7:0] mask);
        int i;
        logic stray;
        stray = 1'b0;
        for (i = 0; i < bound; i++) begin
            @(negedge clk);
            if ((detector_stimulus & ~mask) !== 8'h00) stray = 1'b1;
            if (test_busy === 1'b0 && test_outcome_flag === 1'b1) break;
        end
        if (i == bound) begin
            n_errors++;
            $display("[FAIL] %0t ns: test did not finish", $time);
            end_of_test();
        end else begin
            check({7'h00, stray}, 8'h00);
            @(negedge clk);
        end
    endtask : wait_done

    // A full sweep runs all detectors, then clears the mode by itself.
    task automatic t_full_sweep();
        sw(1'b1, VDST_MODE_FULL, 1'b0, 4'h0, 1'b0);
        @(negedge clk);
        check({7'h00, test_busy}, 8'h01);
        check(detector_stimulus, 8'h01);
        wait_done(1300, 8'hff);
        check({6'h00, test_mode_select}, 8'h00);
        check({7'h00, test_outcome_flag}, 8'h01);
        check({7'h00, test_pass}, 8'h01);
    endtask : t_full_sweep

    // With the mode off, clearing the flag must not start anything.
    task automatic t_clear_idle();
        sw(1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
        @(negedge clk);
        check({7'h00, test_outcome_flag}, 8'h00);
        check({7'h00, test_busy}, 8'h00);
    endtask : t_clear_idle

    // A single test drives only detector 2 and leaves the mode set.
    task automatic t_single();
        sw(1'b0, 2'h0, 1'b1, 4'h3, 1'b0);
        @(negedge clk);
        check({7'h00, test_busy}, 8'h00);
        sw(1'b1, VDST_MODE_FULL, 1'b0, 4'h0, 1'b0);
        @(negedge clk);
        check(detector_stimulus, 8'h04);
        wait_done(200, 8'h04);
        check({6'h00, test_mode_select}, 8'h01);
        check({4'h0, single_detector_select}, 8'h03);
        check({7'h00, test_outcome_flag}, 8'h01);
        check({7'h00, test_pass}, 8'h01);
    endtask : t_single

    // Clearing the flag with the mode still set reruns the test; a dead
    // detector this time makes the outcome a failure.
    task automatic t_rerun();
        echo = 1'b0;
        sw(1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
        @(negedge clk);
        check({7'h00, test_busy}, 8'h01);
        check(detector_stimulus, 8'h04);
        wait_done(200, 8'h04);
        check({7'h00, test_pass}, 8'h00);
        echo = 1'b1;
    endtask : t_rerun

    // Mode zeroed first, then the flag cleared: no repeat test follows.
    task automatic t_safe_clear();
        sw(1'b1, VDST_MODE_OFF, 1'b0, 4'h0, 1'b0);
        sw(1'b0, 2'h0, 1'b0, 4'h0, 1'b1);
        @(negedge clk);
        check({7'h00, test_busy}, 8'h00);
        check({7'h00, test_outcome_flag}, 8'h00);
        repeat (3) @(negedge clk);
        check(detector_stimulus, 8'h00);
    endtask : t_safe_clear

    // Mode 10 with an out-of-range select starts nothing; a later select
    // write while the mode is set starts a single test on detector 0.
    task automatic t_select_start();
        sw(1'b1, 2'h2, 1'b1, 4'h9, 1'b0);
        @(negedge clk);
        check({7'h00, test_busy}, 8'h00);
        check(detector_stimulus, 8'h00);
        check({4'h0, single_detector_select}, 8'h09);
        sw(1'b0, 2'h0, 1'b1, 4'h1, 1'b0);
        @(negedge clk);
        check({7'h00, test_busy}, 8'h01);
        check(detector_stimulus, 8'h01);
        wait_done(200, 8'h01);
        check({6'h00, test_mode_select}, 8'h02);
        check({7'h00, test_outcome_flag}, 8'h01);
        check({7'h00, test_pass}, 8'h01);
    endtask : t_select_start

    // Main sequence: reset, then each scenario in turn.
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sw_wr = '0;
        echo = 1'b1;
        n_errors = 0;
        checks = 0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check({4'h0, test_mode_select, test_busy, test_outcome_flag},
              8'h00);
        t_full_sweep();
        t_clear_idle();
        t_single();
        t_rerun();
        t_safe_clear();
        t_select_start();
        end_of_test();
    end
endmodule : tb_vdst_top
`default_nettype wire
